// ### src/checksum_engine.sv
// What this block does
// - The result is the sum of all terms of the chosen formula kept to 16 bits.
// - A plain range term adds every program word from start to end address inclusive.
// - A folded range term adds, per word, the XNOR of its upper and lower seven bits.
// - The identifier term packs the low nibble of each of four ID words, ID zero on top.
// - Standard 2K with protection off sums words 0x000 to 0x7FF plus config AND 0x3F7F.
// - Partly protected standard parts sum only the unprotected low range plus config and ID.
// - Fully protected standard parts add no words, only masked config plus packed ID.
// - The older 4K family masks config with 0x003F, adds 0x3F80 and folds protected words.
// - The display 4K family masks config with 0x3F3F, range choice as the standard parts.
// - The 8K family protected from 0x800 up sums words 0x0000 to 0x07FF plus config and ID.
// - A pattern of 0x25E6 at address zero and top gives 0x034D on 2K with protection off.
`timescale 1ns/1ps

module checksum_engine (
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       start_i,
    input  wire checksum_pkg::family_t      family_i,
    input  wire checksum_pkg::protect_t     protect_i,
    input  wire logic [13:0]                configuration_word_i,
    input  wire logic [13:0]                identifier_word_zero_i,
    input  wire logic [13:0]                identifier_word_one_i,
    input  wire logic [13:0]                identifier_word_two_i,
    input  wire logic [13:0]                identifier_word_three_i,
    input  wire logic [13:0]                word_i,
    input  wire logic                       word_valid_i,
    output logic      [12:0]                word_addr_o,
    output logic                            busy_o,
    output logic                            done_o,
    output logic      [15:0]                checksum_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.
    checksum_pkg::state_t  state_r,     state_nxt;
    logic                  busy_r,      busy_nxt;
    logic                  fold_r,      fold_nxt;
    logic                  plain_en_r,  plain_en_nxt;
    logic [12:0]           plain_end_r, plain_end_nxt;
    logic [12:0]           last_r,      last_nxt;
    logic [12:0]           addr_r,      addr_nxt;
    logic [15:0]           acc_r,       acc_nxt;
    logic [15:0]           checksum_r,  checksum_nxt;
    logic                  done_r,      done_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Start-time decode of the formula.
    logic [12:0]           top_s;
    logic [13:0]           mask_s;
    logic                  fold_s;
    logic                  plain_en_s;
    logic [12:0]           plain_end_s;
    logic [12:0]           last_s;
    logic                  skip_s;
    logic [15:0]           id_term;
    logic [15:0]           fixed_s;

    always_comb begin
        case (family_i)
            checksum_pkg::FAM_STD_2K: begin
                top_s  = checksum_pkg::TOP_2K;
                mask_s = checksum_pkg::MASK_STD;
            end
            checksum_pkg::FAM_FOLD_4K: begin
                top_s  = checksum_pkg::TOP_4K;
                mask_s = checksum_pkg::MASK_FOLD;
            end
            checksum_pkg::FAM_DISP_4K: begin
                top_s  = checksum_pkg::TOP_4K;
                mask_s = checksum_pkg::MASK_DISP;
            end
            checksum_pkg::FAM_WIDE_8K: begin
                top_s  = checksum_pkg::TOP_8K;
                mask_s = checksum_pkg::MASK_DISP;
            end
            default: begin
                top_s  = checksum_pkg::TOP_2K;
                mask_s = checksum_pkg::MASK_STD;
            end
        endcase

        fold_s = (family_i == checksum_pkg::FAM_FOLD_4K);

        // Protection removes the upper half or three quarters of the plain range.
        case (protect_i)
            checksum_pkg::PROT_OFF:     plain_end_s = top_s;
            checksum_pkg::PROT_HALF:    plain_end_s = top_s >> 1;
            checksum_pkg::PROT_UPPER3Q: plain_end_s = top_s >> 2;
            default:                    plain_end_s = checksum_pkg::ADDR_ZERO;
        endcase
        plain_en_s = (protect_i != checksum_pkg::PROT_ALL);
        last_s     = fold_s ? top_s : plain_end_s;
        skip_s     = !fold_s && !plain_en_s;

        id_term = {identifier_word_zero_i[3:0], identifier_word_one_i[3:0],
                   identifier_word_two_i[3:0], identifier_word_three_i[3:0]};

        fixed_s = {2'b00, configuration_word_i & mask_s};
        if (fold_s) begin
            fixed_s = fixed_s + checksum_pkg::FOLD_CONST;
        end else if (protect_i != checksum_pkg::PROT_OFF) begin
            fixed_s = fixed_s + id_term;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-word term.
    logic [6:0]            folded;
    logic [15:0]           term;
    logic                  take;
    logic                  is_last;

    xnor_fold u_fold (
        .word_i   (word_i),
        .folded_o (folded)
    );

    always_comb begin
        take    = (state_r == checksum_pkg::ST_RUN) && word_valid_i;
        is_last = (addr_r == last_r);
        if (plain_en_r && (addr_r <= plain_end_r)) begin
            term = {2'b00, word_i};
        end else if (fold_r) begin
            term = {9'h000, folded};
        end else begin
            term = checksum_pkg::SUM_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing.
    always_comb begin
        state_nxt     = state_r;
        busy_nxt      = busy_r;
        fold_nxt      = fold_r;
        plain_en_nxt  = plain_en_r;
        plain_end_nxt = plain_end_r;
        last_nxt      = last_r;
        addr_nxt      = addr_r;
        acc_nxt       = acc_r;
        checksum_nxt  = checksum_r;
        done_nxt      = 1'b0;
        if (start_i) begin
            fold_nxt      = fold_s;
            plain_en_nxt  = plain_en_s;
            plain_end_nxt = plain_end_s;
            last_nxt      = last_s;
            addr_nxt      = checksum_pkg::ADDR_ZERO;
            acc_nxt       = fixed_s;
            if (skip_s) begin
                checksum_nxt = fixed_s;
                done_nxt     = 1'b1;
                state_nxt    = checksum_pkg::ST_IDLE;
                busy_nxt     = 1'b0;
            end else begin
                state_nxt = checksum_pkg::ST_RUN;
                busy_nxt  = 1'b1;
            end
        end else begin
            case (state_r)
                checksum_pkg::ST_IDLE: begin
                    busy_nxt = 1'b0;
                end
                checksum_pkg::ST_RUN: begin
                    if (take) begin
                        // Plain 16-bit wrap; this is what yields 0x034D for the pattern.
                        acc_nxt = acc_r + term;
                        if (is_last) begin
                            checksum_nxt = acc_r + term;
                            done_nxt     = 1'b1;
                            state_nxt    = checksum_pkg::ST_IDLE;
                            busy_nxt     = 1'b0;
                        end else begin
                            addr_nxt = addr_r + 13'h0001;
                        end
                    end
                end
                default: begin
                    state_nxt = checksum_pkg::ST_IDLE;
                    busy_nxt  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_r     <= checksum_pkg::ST_IDLE;
            busy_r      <= 1'b0;
            fold_r      <= 1'b0;
            plain_en_r  <= 1'b0;
            plain_end_r <= checksum_pkg::ADDR_ZERO;
            last_r      <= checksum_pkg::ADDR_ZERO;
            addr_r      <= checksum_pkg::ADDR_ZERO;
            acc_r       <= checksum_pkg::SUM_ZERO;
            checksum_r  <= checksum_pkg::SUM_ZERO;
            done_r      <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            busy_r      <= busy_nxt;
            fold_r      <= fold_nxt;
            plain_en_r  <= plain_en_nxt;
            plain_end_r <= plain_end_nxt;
            last_r      <= last_nxt;
            addr_r      <= addr_nxt;
            acc_r       <= acc_nxt;
            checksum_r  <= checksum_nxt;
            done_r      <= done_nxt;
        end
    end

    assign word_addr_o = addr_r;
    assign busy_o      = busy_r;
    assign done_o      = done_r;
    assign checksum_o  = checksum_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence last_word_s;
        !start_i && take && is_last;
    endsequence

    sequence mid_word_s;
        !start_i && take && !is_last;
    endsequence

    result_wrap_a: assert property (
        last_word_s |=> done_o && (checksum_o == 16'($past(acc_r) + $past(term))))
        else $error("checksum not the wrapped sum at the last word");

    plain_add_a: assert property (
        mid_word_s and (plain_en_r && addr_r <= plain_end_r)
        |=> acc_r == 16'($past(acc_r) + {2'b00, $past(word_i)}))
        else $error("plain word not added to the sum");

    fold_add_a: assert property (
        mid_word_s and (fold_r && !(plain_en_r && addr_r <= plain_end_r))
        |=> acc_r == 16'($past(acc_r) + {9'h000, ~($past(word_i[13:7]) ^ $past(word_i[6:0]))}))
        else $error("folded word term wrong");

    all_protect_a: assert property (
        start_i && family_i == checksum_pkg::FAM_STD_2K && protect_i == checksum_pkg::PROT_ALL
        |=> done_o && !busy_o
            && checksum_o == 16'({2'b00, $past(configuration_word_i) & 14'h3f7f}
               + {$past(identifier_word_zero_i[3:0]), $past(identifier_word_one_i[3:0]),
                  $past(identifier_word_two_i[3:0]), $past(identifier_word_three_i[3:0])}))
        else $error("fully protected result wrong");

    std_range_a: assert property (
        start_i && family_i == checksum_pkg::FAM_STD_2K && protect_i == checksum_pkg::PROT_OFF
        |=> busy_o && last_r == 13'h07ff && plain_end_r == 13'h07ff && addr_r == 13'h0000)
        else $error("standard 2K range wrong");

    half_range_a: assert property (
        start_i && family_i == checksum_pkg::FAM_STD_2K && protect_i == checksum_pkg::PROT_HALF
        |=> last_r == 13'h03ff && !fold_r)
        else $error("half protected range wrong");

    fold_fixed_a: assert property (
        start_i && family_i == checksum_pkg::FAM_FOLD_4K
        |=> fold_r && last_r == 13'h0fff
            && acc_r == 16'({2'b00, $past(configuration_word_i) & 14'h003f} + 16'h3f80))
        else $error("folding family fixed term wrong");

    disp_mask_a: assert property (
        start_i && family_i == checksum_pkg::FAM_DISP_4K && protect_i == checksum_pkg::PROT_OFF
        |=> acc_r == {2'b00, $past(configuration_word_i) & 14'h3f3f} && last_r == 13'h0fff)
        else $error("display family mask wrong");

    wide_range_a: assert property (
        start_i && family_i == checksum_pkg::FAM_WIDE_8K
        && protect_i == checksum_pkg::PROT_UPPER3Q
        |=> plain_end_r == 13'h07ff && last_r == 13'h07ff)
        else $error("8K protected range wrong");

    done_pulse_a: assert property (
        done_o |=> !done_o || $past(start_i))
        else $error("done longer than one cycle");

    step_addr_a: assert property (
        mid_word_s |=> addr_r == 13'($past(addr_r) + 13'h0001) && busy_o)
        else $error("address did not step");

    idle_quiet_a: assert property (
        !busy_o && !start_i |=> !busy_o && $stable(word_addr_o))
        else $error("engine left idle without a start");

    disp_half_a: assert property (
        start_i && family_i == checksum_pkg::FAM_DISP_4K && protect_i == checksum_pkg::PROT_HALF
        |=> plain_end_r == 13'h07ff && last_r == 13'h07ff && !fold_r)
        else $error("display family half range wrong");

    wide_half_a: assert property (
        start_i && family_i == checksum_pkg::FAM_WIDE_8K && protect_i == checksum_pkg::PROT_HALF
        |=> plain_end_r == 13'h0fff && last_r == 13'h0fff && !fold_r)
        else $error("8K half protected range wrong");

    fold_all_a: assert property (
        start_i && family_i == checksum_pkg::FAM_FOLD_4K && protect_i == checksum_pkg::PROT_ALL
        |=> fold_r && !plain_en_r && busy_o && last_r == 13'h0fff)
        else $error("folding family did not fold every word");

endmodule : checksum_engine

// ### src/checksum_pkg.sv
package checksum_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths.
    localparam int WORD_W   = 14;
    localparam int SUM_W    = 16;
    localparam int ADDR_W   = 13;
    localparam int FOLD_W   = 7;
    localparam int NIBBLE_W = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Highest program address of each memory size.
    localparam logic [ADDR_W-1:0] TOP_2K = 13'h07ff;
    localparam logic [ADDR_W-1:0] TOP_4K = 13'h0fff;
    localparam logic [ADDR_W-1:0] TOP_8K = 13'h1fff;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration word masks and the constant term of the folding family.
    localparam logic [WORD_W-1:0] MASK_STD   = 14'h3f7f;
    localparam logic [WORD_W-1:0] MASK_FOLD  = 14'h003f;
    localparam logic [WORD_W-1:0] MASK_DISP  = 14'h3f3f;
    localparam logic [SUM_W-1:0]  FOLD_CONST = 16'h3f80;
    localparam logic [SUM_W-1:0]  SUM_ZERO   = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO  = 13'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Families, protection levels and engine states.
    typedef enum logic [1:0] {
        FAM_STD_2K  = 2'b00,
        FAM_FOLD_4K = 2'b01,
        FAM_DISP_4K = 2'b10,
        FAM_WIDE_8K = 2'b11
    } family_t;

    typedef enum logic [1:0] {
        PROT_OFF     = 2'b00,
        PROT_HALF    = 2'b01,
        PROT_UPPER3Q = 2'b10,
        PROT_ALL     = 2'b11
    } protect_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } state_t;

endpackage : checksum_pkg

// ### src/xnor_fold.sv
`timescale 1ns/1ps

module xnor_fold (
    input  wire logic [13:0] word_i,
    output logic      [6:0]  folded_o
);

    // Upper seven bits XNOR lower seven bits.
    always_comb begin
        folded_o = ~(word_i[13:7] ^ word_i[6:0]);
    end

endmodule : xnor_fold

// ### verification/checksum_engine_bench.sv
`timescale 1ns/1ps

module checksum_engine_bench;

    logic                   clk_sys_i, rst_n_i, start_i, word_valid_i, busy_o, done_o, stall;
    checksum_pkg::family_t  family_i;
    checksum_pkg::protect_t protect_i;
    logic [13:0]            cfg_word, id0, id1, id2, id3, word_i;
    logic [12:0]            word_addr_o, top;
    logic [15:0]            checksum_o, res;
    int                     n_errors, tests_run, n_taken, cycles;

    checksum_engine dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .start_i(start_i),
        .family_i(family_i), .protect_i(protect_i), .configuration_word_i(cfg_word),
        .identifier_word_zero_i(id0), .identifier_word_one_i(id1),
        .identifier_word_two_i(id2), .identifier_word_three_i(id3), .word_i(word_i),
        .word_valid_i(word_valid_i), .word_addr_o(word_addr_o), .busy_o(busy_o),
        .done_o(done_o), .checksum_o(checksum_o));

    mem_image image_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .stall_i(stall), .top_i(top),
        .addr_i(word_addr_o), .word_o(word_i), .valid_o(word_valid_i));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude;
        $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    // Independent model of the checksum; also gives the number of words the walk must take.
    function automatic logic [15:0] ref_sum(input logic [1:0] fam, input logic [1:0] prot,
                                            input logic [12:0] t, output int nw);
        logic [15:0] acc;
        logic [13:0] w;
        int          last;
        last = (prot == 2'b00) ? t : (prot == 2'b01) ? (t >> 1) : (t >> 2);
        if (prot == 2'b11) last = -1;
        if (fam == 2'b01) begin
            acc = {2'b00, cfg_word & 14'h003f} + 16'h3f80;
            nw = t + 1;
            for (int a = 0; a <= t; a++) begin
                w = (a == 0 || a == t) ? 14'h25e6 : 14'h3fff;
                if (a <= last) acc += {2'b00, w};
                else acc += {9'h000, ~(w[13:7] ^ w[6:0])};
            end
        end else begin
            acc = {2'b00, cfg_word & ((fam == 2'b00) ? 14'h3f7f : 14'h3f3f)};
            if (prot != 2'b00) acc += {id0[3:0], id1[3:0], id2[3:0], id3[3:0]};
            nw = last + 1;
            for (int a = 0; a <= last; a++) acc += (a == 0 || a == t) ? 16'h25e6 : 16'h3fff;
        end
        return acc;
    endfunction : ref_sum

    // One complete checksum walk, judged on result, word count, pulse width and idle state.
    task automatic do_checksum(input logic [1:0] fam, input logic [1:0] prot, input logic st,
                               input logic [13:0] cfg, output logic [15:0] got);
        logic [12:0] t;
        logic [15:0] exp;
        int          nw, k;
        t = (fam == 2'b00) ? checksum_pkg::TOP_2K :
            (fam == 2'b11) ? checksum_pkg::TOP_8K : checksum_pkg::TOP_4K;
        @(posedge clk_sys_i);
        family_i  <= checksum_pkg::family_t'(fam);
        protect_i <= checksum_pkg::protect_t'(prot);
        top       <= t;
        stall     <= st;
        cfg_word  <= cfg;
        start_i   <= 1'b1;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        n_taken = 0;
        k = 0;
        // A walk with no words answers at this very edge, so look before waiting.
        #1;
        while (done_o !== 1'b1 && k < 20000) begin
            @(posedge clk_sys_i);
            #1;
            k++;
        end
        exp = ref_sum(fam, prot, t, nw);
        got = checksum_o;
        check("done", {15'h0000, done_o}, 16'h0001);
        check("busy", {15'h0000, busy_o}, 16'h0000);
        check("checksum", checksum_o, exp);
        check("words", n_taken[15:0], nw[15:0]);
        @(posedge clk_sys_i);
        #1;
        check("done_pulse", {15'h0000, done_o}, 16'h0000);
        check("held", checksum_o, exp);
    endtask : do_checksum

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        check("rst_busy", {15'h0000, busy_o}, 16'h0000);
        check("rst_done", {15'h0000, done_o}, 16'h0000);
        check("rst_sum", checksum_o, 16'h0000);
        check("rst_addr", {3'b000, word_addr_o}, 16'h0000);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_reference;
        do_checksum(2'b00, 2'b00, 1'b0, 14'h3fff, res);
        check("ref_2k_off", res, 16'h034d);
        do_checksum(2'b01, 2'b11, 1'b0, 14'h000f, res);
        check("ref_fold_all", res, 16'h2f35);
        $display("test_reference done");
    endtask : test_reference

    task automatic test_all_codes;
        for (int f = 0; f < 4; f++) begin
            for (int p = 0; p < 4; p++) begin
                do_checksum(f[1:0], p[1:0], 1'b0, 14'h3ffe, res);
            end
        end
        $display("test_all_codes done");
    endtask : test_all_codes

    task automatic test_stall_ids;
        @(posedge clk_sys_i);
        id0 <= 14'h0012;
        id1 <= 14'h0037;
        id2 <= 14'h0004;
        id3 <= 14'h0026;
        do_checksum(2'b00, 2'b11, 1'b0, 14'h0000, res);
        check("id_pack", res, 16'h2746);
        do_checksum(2'b00, 2'b01, 1'b1, 14'h3fff, res);
        do_checksum(2'b11, 2'b10, 1'b1, 14'h1234, res);
        $display("test_stall_ids done");
    endtask : test_stall_ids

    task automatic test_restart;
        do_checksum(2'b10, 2'b01, 1'b0, 14'h2a55, res);
        @(posedge clk_sys_i);
        start_i <= 1'b1;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        // A bare restart walks from address zero again, so the word count starts over.
        n_taken = 0;
        repeat (50) @(posedge clk_sys_i);
        do_checksum(2'b00, 2'b00, 1'b0, 14'h1111, res);
        @(posedge clk_sys_i);
        start_i <= 1'b1;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        n_taken = 0;
        repeat (40) @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        #1;
        test_reset();
        $display("test_restart done");
    endtask : test_restart

    ////////////////////////////////////////////////////////////////////////////////
    // Every taken word must come at the next address in order.
    always @(posedge clk_sys_i) begin
        if (busy_o === 1'b1 && word_valid_i === 1'b1 && start_i === 1'b0) begin
            check("word_addr", {3'b000, word_addr_o}, n_taken[15:0]);
            n_taken++;
        end
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 90000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        rst_n_i   = 1'b0;
        start_i   = 1'b0;
        stall     = 1'b0;
        top       = checksum_pkg::TOP_2K;
        family_i  = checksum_pkg::FAM_STD_2K;
        protect_i = checksum_pkg::PROT_OFF;
        cfg_word  = 14'h3fff;
        id0       = 14'h3fff;
        id1       = 14'h3fff;
        id2       = 14'h3fff;
        id3       = 14'h3fff;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        #1;
        test_reset();
        test_reference();
        test_all_codes();
        test_stall_ids();
        test_restart();
        conclude();
    end

endmodule : checksum_engine_bench

// ### verification/mem_image.sv
`timescale 1ns/1ps

module mem_image (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        stall_i,
    input  wire logic [12:0] top_i,
    input  wire logic [12:0] addr_i,
    output logic      [13:0] word_o,
    output logic             valid_o
);

    logic [13:0] image_w;

    // Marker word at the first and the last address, erased cells everywhere else.
    assign image_w = (addr_i == 13'h0000 || addr_i == top_i) ? 14'h25e6 : 14'h3fff;

    // While no word is offered the lines carry the inverse, so a stale sample shows up.
    assign word_o = valid_o ? image_w : ~image_w;

    // A slow image offers a word only every other cycle.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) valid_o <= 1'b0;
        else valid_o <= stall_i ? ~valid_o : 1'b1;
    end

endmodule : mem_image
